// *** logic/tts_trail_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_trail_sink
    import tts_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic IN_CK,
    input wire logic [7:0] IN_D,
    input wire logic IN_FS,
    input wire logic SERVER_SIGNAL_FAIL,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic OUT_CK,
    output logic [7:0] OUT_D,
    output logic OUT_FS,
    output logic [127:0] ACCEPTED_TRACE_ID,
    output logic TC_UNEQUIPPED_DEFECT,
    output logic TC_CONNECTION_LOSS_DEFECT,
    output logic TRACE_MISMATCH_DEFECT,
    output logic FAR_DEFECT_INDICATION_DEFECT,
    output logic FAR_OUTGOING_DEFECT_DEFECT,
    output logic INCOMING_ALARM_DEFECT,
    output logic ALARM_INSERT_REQUEST,
    output logic NEAR_ERRORED_TC_BLOCK,
    output logic NEAR_ERRORED_VC_BLOCK,
    output logic FAR_ERRORED_TC_BLOCK,
    output logic FAR_ERRORED_VC_BLOCK
);
    logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
    logic fs_s1_reg, fs_s2_reg, ssf_s1_reg, ssf_s2_reg;
    logic [7:0] d_s1_reg, d_s2_reg;
    logic byte_stb, n1_stb, is_b3, is_n1, started_reg, prev_valid_reg;
    logic [9:0] pos_reg, pos_next;
    logic [7:0] acc_reg, bip_prev_reg;
    logic [3:0] err_cnt_reg, iec_cnt;
    logic [7:0] b3_orig_prev_reg, b3_new_prev_reg, n1_orig_prev_reg;
    logic [7:0] b3_next, out_d_reg;
    logic out_ck_reg, out_fs_reg;
    logic near_tc_reg, near_vc_reg, far_tc_reg, far_vc_reg;
    logic in_mf_reg, miss_reg;
    logic [6:0] mf_cnt_reg, mf_cnt_next;
    logic [15:0] mf_shift_reg, mf_shift_next;
    logic [127:0] rx_ti_reg, rx_ti_next, cand_ti_reg, acc_ti_reg;
    logic [127:0] exp_ti_reg;
    logic [1:0] match_reg;
    logic tim_reg, tim_dis_reg, ais_req;
    logic uneq, iais, rdi, odi;
    logic ack_reg, wr_take;
    logic [31:0] rd_mux, rd_data_reg;

    // Link pins are sampled twice before use; the link clock is only a level.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            ck_s3_reg <= 1'b0;
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            ssf_s1_reg <= 1'b0;
            ssf_s2_reg <= 1'b0;
            d_s1_reg <= 8'h00;
            d_s2_reg <= 8'h00;
        end else begin
            ck_s1_reg <= IN_CK;
            ck_s2_reg <= ck_s1_reg;
            ck_s3_reg <= ck_s2_reg;
            fs_s1_reg <= IN_FS;
            fs_s2_reg <= fs_s1_reg;
            ssf_s1_reg <= SERVER_SIGNAL_FAIL;
            ssf_s2_reg <= ssf_s1_reg;
            d_s1_reg <= IN_D;
            d_s2_reg <= d_s1_reg;
        end
    end

    assign byte_stb = ck_s2_reg & ~ck_s3_reg;
    assign pos_next = fs_s2_reg ? 10'h000 : pos_reg + 10'h001;
    assign is_b3 = started_reg && (pos_next == B3_POS);
    assign is_n1 = started_reg && (pos_next == N1_POS);
    assign n1_stb = byte_stb && is_n1;

    always_ff @(posedge CLK) begin
        if (RST) begin
            pos_reg <= 10'h000;
            started_reg <= 1'b0;
            prev_valid_reg <= 1'b0;
        end else if (byte_stb) begin
            pos_reg <= pos_next;
            if (fs_s2_reg) begin
                started_reg <= 1'b1;
                prev_valid_reg <= started_reg;
            end
        end
    end

    // Parity runs over the incoming bytes as received, B3 and N1 included.
    always_ff @(posedge CLK) begin
        if (RST) begin
            acc_reg <= 8'h00;
            bip_prev_reg <= 8'h00;
            err_cnt_reg <= 4'h0;
        end else if (byte_stb) begin
            if (fs_s2_reg) begin
                bip_prev_reg <= acc_reg;
                acc_reg <= d_s2_reg;
            end else begin
                acc_reg <= acc_reg ^ d_s2_reg;
            end
            if (is_b3) begin
                err_cnt_reg <= tts_popcount(bip_prev_reg ^ d_s2_reg);
            end
        end
    end

    assign iec_cnt = tts_iec_errors(d_s2_reg[7:4]);

    always_ff @(posedge CLK) begin
        if (RST) begin
            near_tc_reg <= 1'b0;
            near_vc_reg <= 1'b0;
            far_tc_reg <= 1'b0;
            far_vc_reg <= 1'b0;
        end else begin
            near_tc_reg <= n1_stb && prev_valid_reg &&
                           (iec_cnt != err_cnt_reg);
            near_vc_reg <= n1_stb && prev_valid_reg &&
                           (err_cnt_reg != 4'h0);
            far_tc_reg <= n1_stb && d_s2_reg[3];
            far_vc_reg <= n1_stb && d_s2_reg[2];
        end
    end

    assign b3_next = d_s2_reg ^ b3_orig_prev_reg ^ b3_new_prev_reg ^
                     n1_orig_prev_reg ^ N1_TERM;

    always_ff @(posedge CLK) begin
        if (RST) begin
            b3_orig_prev_reg <= 8'h00;
            b3_new_prev_reg <= 8'h00;
            n1_orig_prev_reg <= 8'h00;
        end else if (byte_stb) begin
            if (is_b3) begin
                b3_orig_prev_reg <= d_s2_reg;
                b3_new_prev_reg <= b3_next;
            end
            if (is_n1) begin
                n1_orig_prev_reg <= d_s2_reg;
            end
        end
    end

    // The output clock follows one cycle behind the data so the far side
    // always sees settled data at its rising edge.
    always_ff @(posedge CLK) begin
        if (RST) begin
            out_d_reg <= 8'h00;
            out_fs_reg <= 1'b0;
            out_ck_reg <= 1'b0;
        end else begin
            out_ck_reg <= ck_s3_reg;
            if (byte_stb) begin
                out_fs_reg <= fs_s2_reg;
                if (ais_req) begin
                    out_d_reg <= AIS_BYTE;
                end else if (is_n1) begin
                    out_d_reg <= N1_TERM;
                end else if (is_b3) begin
                    out_d_reg <= b3_next;
                end else begin
                    out_d_reg <= d_s2_reg;
                end
            end
        end
    end

    assign mf_shift_next = {mf_shift_reg[13:0], d_s2_reg[1], d_s2_reg[0]};
    assign mf_cnt_next = (mf_cnt_reg == MF_LEN) ? 7'h01 : mf_cnt_reg + 7'h01;

    // Search anywhere while out of multiframe, check only at frame 8 when in.
    always_ff @(posedge CLK) begin
        if (RST) begin
            in_mf_reg <= 1'b0;
            miss_reg <= 1'b0;
            mf_cnt_reg <= 7'h01;
            mf_shift_reg <= 16'h0000;
        end else if (n1_stb) begin
            mf_shift_reg <= mf_shift_next;
            if (!in_mf_reg) begin
                if (mf_shift_next == FAS_WORD) begin
                    in_mf_reg <= 1'b1;
                    mf_cnt_reg <= FAS_LAST;
                    miss_reg <= 1'b0;
                end
            end else begin
                mf_cnt_reg <= mf_cnt_next;
                if (mf_cnt_next == FAS_LAST) begin
                    if (mf_shift_next == FAS_WORD) begin
                        miss_reg <= 1'b0;
                    end else if (miss_reg) begin
                        in_mf_reg <= 1'b0;
                        miss_reg <= 1'b0;
                    end else begin
                        miss_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign rx_ti_next = {rx_ti_reg[125:0], d_s2_reg[1], d_s2_reg[0]};

    // Acceptance needs three identical multiframes; at 9.5 ms each the
    // mismatch verdict settles far inside one second.
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_ti_reg <= 128'h0;
            cand_ti_reg <= 128'h0;
            acc_ti_reg <= 128'h0;
            match_reg <= 2'h0;
        end else if (n1_stb && in_mf_reg && mf_cnt_next >= TI_FIRST &&
                     mf_cnt_next <= TI_LAST) begin
            rx_ti_reg <= rx_ti_next;
            if (mf_cnt_next == TI_LAST) begin
                if (rx_ti_next != cand_ti_reg) begin
                    cand_ti_reg <= rx_ti_next;
                    match_reg <= 2'h1;
                end else if (match_reg != TI_ACCEPT) begin
                    match_reg <= match_reg + 2'h1;
                    if (match_reg == TI_ACCEPT - 2'h1) begin
                        acc_ti_reg <= cand_ti_reg;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tim_reg <= 1'b0;
        end else begin
            tim_reg <= (acc_ti_reg != exp_ti_reg) && !ssf_s2_reg &&
                       !tim_dis_reg;
        end
    end

    tts_persist #(.N(PERSIST_FRAMES)) u_uneq (
        .clk(CLK),
        .rst(RST),
        .sample(n1_stb),
        .value(d_s2_reg == 8'h00),
        .level(uneq)
    );

    tts_persist #(.N(PERSIST_FRAMES)) u_iais (
        .clk(CLK),
        .rst(RST),
        .sample(n1_stb),
        .value(d_s2_reg[7:4] == INC_AIS_CODE),
        .level(iais)
    );

    tts_persist #(.N(PERSIST_FRAMES)) u_rdi (
        .clk(CLK),
        .rst(RST),
        .sample(n1_stb && in_mf_reg && mf_cnt_next == RDI_FRAME),
        .value(d_s2_reg[0]),
        .level(rdi)
    );

    tts_persist #(.N(PERSIST_FRAMES)) u_odi (
        .clk(CLK),
        .rst(RST),
        .sample(n1_stb && in_mf_reg && mf_cnt_next == ODI_FRAME),
        .value(d_s2_reg[1]),
        .level(odi)
    );

    assign ais_req = uneq || tim_reg || !in_mf_reg;

    // Register slave: one wait cycle, then the answer stands for one cycle.
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;
    assign wr_take = AVS_WRITE && ack_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tim_dis_reg <= 1'b0;
            exp_ti_reg <= 128'h0;
        end else if (wr_take) begin
            if (AVS_ADDRESS[5:2] == REG_CTRL[5:2] && AVS_BYTEENABLE[0]) begin
                tim_dis_reg <= AVS_WRITEDATA[CTRL_TIM_DIS];
            end
            for (int k = 0; k < 4; k++) begin
                if (AVS_ADDRESS[5:2] == REG_EXP_TI[5:2] + 4'(k)) begin
                    exp_ti_reg[127 - 32*k -: 32] <= tts_be_merge(
                        exp_ti_reg[127 - 32*k -: 32], AVS_WRITEDATA,
                        AVS_BYTEENABLE);
                end
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        if (AVS_ADDRESS[5:2] == REG_CTRL[5:2]) begin
            rd_mux[CTRL_TIM_DIS] = tim_dis_reg;
        end
        if (AVS_ADDRESS[5:2] == REG_STATUS[5:2]) begin
            rd_mux[ST_UNEQ] = uneq;
            rd_mux[ST_LTC] = !in_mf_reg;
            rd_mux[ST_TIM] = tim_reg;
            rd_mux[ST_RDI] = rdi;
            rd_mux[ST_ODI] = odi;
            rd_mux[ST_IAIS] = iais;
            rd_mux[ST_AIS] = ais_req;
            rd_mux[ST_IM] = in_mf_reg;
        end
        for (int k = 0; k < 4; k++) begin
            if (AVS_ADDRESS[5:2] == REG_EXP_TI[5:2] + 4'(k)) begin
                rd_mux = exp_ti_reg[127 - 32*k -: 32];
            end
            if (AVS_ADDRESS[5:2] == REG_ACC_TI[5:2] + 4'(k)) begin
                rd_mux = acc_ti_reg[127 - 32*k -: 32];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_data_reg <= 32'h0;
        end else if (AVS_READ && !ack_reg) begin
            rd_data_reg <= rd_mux;
        end
    end

    assign AVS_READDATA = rd_data_reg;
    assign OUT_CK = out_ck_reg;
    assign OUT_D = out_d_reg;
    assign OUT_FS = out_fs_reg;
    assign ACCEPTED_TRACE_ID = acc_ti_reg;
    assign TC_UNEQUIPPED_DEFECT = uneq;
    assign TC_CONNECTION_LOSS_DEFECT = !in_mf_reg;
    assign TRACE_MISMATCH_DEFECT = tim_reg;
    assign FAR_DEFECT_INDICATION_DEFECT = rdi;
    assign FAR_OUTGOING_DEFECT_DEFECT = odi;
    assign INCOMING_ALARM_DEFECT = iais;
    assign ALARM_INSERT_REQUEST = ais_req;
    assign NEAR_ERRORED_TC_BLOCK = near_tc_reg;
    assign NEAR_ERRORED_VC_BLOCK = near_vc_reg;
    assign FAR_ERRORED_TC_BLOCK = far_tc_reg;
    assign FAR_ERRORED_VC_BLOCK = far_vc_reg;

    a_oom_two_miss: assert property (@(posedge CLK) disable iff (RST)
        n1_stb && in_mf_reg && mf_cnt_next == FAS_LAST && miss_reg &&
        mf_shift_next != FAS_WORD |=> TC_CONNECTION_LOSS_DEFECT)
        else $error("Alignment not lost after two errored words.");
    a_im_clean_word: assert property (@(posedge CLK) disable iff (RST)
        n1_stb && !in_mf_reg && mf_shift_next == FAS_WORD
        |=> !TC_CONNECTION_LOSS_DEFECT && mf_cnt_reg == FAS_LAST)
        else $error("Alignment not regained on a clean word.");
    a_n1_zeroed: assert property (@(posedge CLK) disable iff (RST)
        byte_stb && is_n1 && !ais_req |=> OUT_D == 8'h00)
        else $error("Outgoing N1 not zero.");
    a_ais_fill: assert property (@(posedge CLK) disable iff (RST)
        byte_stb && ALARM_INSERT_REQUEST |=> OUT_D == 8'hFF)
        else $error("Alarm fill missing.");
    a_tim_ssf_hold: assert property (@(posedge CLK) disable iff (RST)
        ssf_s2_reg [*2] |-> !TRACE_MISMATCH_DEFECT)
        else $error("Mismatch active under server fail.");
    a_tim_disabled: assert property (@(posedge CLK) disable iff (RST)
        $past(tim_dis_reg) |-> !TRACE_MISMATCH_DEFECT)
        else $error("Mismatch active while disabled.");
    a_near_tc_flag: assert property (@(posedge CLK) disable iff (RST)
        n1_stb && prev_valid_reg && iec_cnt != err_cnt_reg
        |=> NEAR_ERRORED_TC_BLOCK ##1 !NEAR_ERRORED_TC_BLOCK)
        else $error("Errored TC block not flagged for one cycle.");
    a_vc_block_flag: assert property (@(posedge CLK) disable iff (RST)
        NEAR_ERRORED_VC_BLOCK |-> $past(err_cnt_reg) != 4'h0 &&
        $past(n1_stb))
        else $error("Errored VC block without parity errors.");
    a_b3_comp: assert property (@(posedge CLK) disable iff (RST)
        byte_stb && is_b3 && !ais_req |=> OUT_D == ($past(d_s2_reg) ^
        $past(b3_orig_prev_reg) ^ $past(b3_new_prev_reg) ^
        $past(n1_orig_prev_reg)))
        else $error("B3 compensation wrong.");
endmodule : tts_trail_sink
`default_nettype wire

// *** shared/tts_pkg.sv ***
// Notes on behaviour
// - Even parity per bit over the whole previous frame, compared with received B3.
// - Errored TC block when own error count differs from incoming code count.
// - Errored VC block when own parity comparison finds any error.
// - B3 and error code of this frame describe the previous frame.
// - Bits 1-4 of N1: codes 0..8 mean that many errors, others zero.
// - Trace identifier from N1 bits 7-8 in frames 9-72, accepted value output.
// - Only the mode without legacy tandem equipment is supported.
// - Remote error from N1 bit 5; remote defect from frame 73 bit 8.
// - Outgoing error from N1 bit 6; outgoing defect from frame 74 bit 7.
// - Search N1 bits 7-8 for the alignment word, then check its position.
// - Two consecutive errored alignment words give out-of-multiframe.
// - One clean alignment word returns to in-multiframe.
// - Outgoing N1 byte is overwritten with zeros.
// - Outgoing B3 is compensated whenever N1 is rewritten.
// - Unequipped after five frames of zero N1, cleared after five non-zero.
// - Loss of tandem connection exactly while out of multiframe.
// - Trace mismatch detected and cleared within one second without errors.
// - Trace mismatch held inactive while server signal fail is asserted.
// - Management bit disables trace mismatch detection.
// - Incoming alarm after five frames of code 1110, cleared after five others.
// - Remote and outgoing defect indications derived from recovered bits.
// - New B3 is XOR of old and new B3 and N1 of last frame and B3.
// - All-ones output within 250 us of alarm request, stop within 250 us.
package tts_pkg;
    localparam logic [9:0] B3_POS = 10'h055;
    localparam logic [9:0] N1_POS = 10'h2A8;
    localparam logic [6:0] MF_LEN = 7'h4C;
    localparam logic [6:0] FAS_LAST = 7'h08;
    localparam logic [6:0] TI_FIRST = 7'h09;
    localparam logic [6:0] TI_LAST = 7'h48;
    localparam logic [6:0] RDI_FRAME = 7'h49;
    localparam logic [6:0] ODI_FRAME = 7'h4A;
    localparam logic [15:0] FAS_WORD = 16'hFFFE;
    localparam logic [3:0] INC_AIS_CODE = 4'hE;
    localparam logic [7:0] N1_TERM = 8'h00;
    localparam logic [7:0] AIS_BYTE = 8'hFF;
    localparam int PERSIST_FRAMES = 5;
    localparam logic [1:0] TI_ACCEPT = 2'h3;
    localparam int AIS_MAX_US = 250;
    localparam int TIM_MAX_MS = 1000;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_EXP_TI = 6'h10;
    localparam logic [5:0] REG_ACC_TI = 6'h20;
    localparam int CTRL_TIM_DIS = 0;
    localparam int ST_UNEQ = 0;
    localparam int ST_LTC = 1;
    localparam int ST_TIM = 2;
    localparam int ST_RDI = 3;
    localparam int ST_ODI = 4;
    localparam int ST_IAIS = 5;
    localparam int ST_AIS = 6;
    localparam int ST_IM = 7;

    function automatic logic [3:0] tts_popcount(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : tts_popcount

    function automatic logic [3:0] tts_iec_errors(input logic [3:0] code);
        return (code <= 4'h8) ? code : 4'h0;
    endfunction : tts_iec_errors

    function automatic logic [31:0] tts_be_merge(input logic [31:0] old,
                                                 input logic [31:0] wdat,
                                                 input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wdat[8*i +: 8];
            end
        end
        return r;
    endfunction : tts_be_merge
endpackage : tts_pkg

// *** logic/tts_persist.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_persist #(
    parameter int unsigned N = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample,
    input wire logic value,
    output logic level
);
    logic level_reg;
    logic [3:0] cnt_reg;

    // A level flips only after N agreeing samples in a row.
    always_ff @(posedge clk) begin
        if (rst) begin
            level_reg <= 1'b0;
            cnt_reg <= 4'h0;
        end else if (sample) begin
            if (value == level_reg) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg == 4'(N - 1)) begin
                level_reg <= value;
                cnt_reg <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    assign level = level_reg;
endmodule : tts_persist
`default_nettype wire

// *** test/tts_tc_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module tts_tc_source
    import tts_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] err_mask,
    input wire logic [3:0] err_code,
    output logic link_ck,
    output logic [7:0] link_d,
    output logic link_fs,
    output var int frame_no,
    output var int byte_no
);
    logic [3:0] ph_reg;
    logic [7:0] par_reg;
    logic [7:0] run_reg;
    logic [7:0] d;
    logic [6:0] mp;
    int nb;
    int nf;
    // Bytes change at the link clock's fall, far from the rise that samples.
    always @(posedge clk) begin
        nb = (byte_no == 764) ? 0 : byte_no + 1;
        nf = (nb == 0) ? frame_no + 1 : frame_no;
        mp = 7'((nf - 1) % 76);
        d = nb[7:0] ^ nf[7:0];
        if (nb == 85) begin
            d = par_reg ^ err_mask;
        end
        if (nb == 680) begin
            d = {err_code, nf[0], nf[1], 2'h0};
            if (mp < 7'h08) begin
                d[1:0] = FAS_WORD[15 - 2 * mp -: 2];
            end
        end
        if (rst) begin
            ph_reg <= 4'h0;
            link_ck <= 1'b0;
            link_d <= 8'h00;
            link_fs <= 1'b0;
            frame_no <= 0;
            byte_no <= 764;
            run_reg <= 8'h00;
            par_reg <= 8'h00;
        end else begin
            ph_reg <= ph_reg + 4'h1;
            if (ph_reg == 4'h7) begin
                link_ck <= 1'b1;
            end
            if (ph_reg == 4'hF) begin
                link_ck <= 1'b0;
                link_d <= d;
                link_fs <= (nb == 0);
                byte_no <= nb;
                frame_no <= nf;
                run_reg <= (nb == 0) ? d : run_reg ^ d;
                if (nb == 0) begin
                    par_reg <= run_reg;
                end
            end
        end
    end
endmodule : tts_tc_source
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
    import tts_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic server_signal_fail = 1'b0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [5:0] av_a = 6'h00;
    logic [31:0] av_wd = 32'h0;
    logic [3:0] av_be = 4'h0;
    logic [31:0] av_q;
    logic av_wait, in_ck, in_fs, ock, out_ck, out_fs;
    logic [7:0] in_d, out_d, ob3, on1;
    logic [7:0] cpar = 8'h00;
    logic [7:0] ppar = 8'h00;
    logic [127:0] acc_ti;
    logic uneq, loss, tim, rdi, odi, iais, aisr, ntc, nvc, ftc, fvc;
    logic [3:0] seen = 4'h0;
    logic [7:0] pm_mask;
    logic [3:0] pm_code;
    int fno, bno;
    int oi = 0;
    int fails = 0;
    int samples_checked = 0;
    logic [7:0] msk [1:10] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h80,
                               8'h10, 8'h07, 8'h00, 8'hFF, 8'h03};
    logic [3:0] cod [1:10] = '{4'hE, 4'hE, 4'hE, 4'hE, 4'hE,
                               4'h1, 4'h3, 4'h9, 4'h8, 4'h0};

    always #5 clk = ~clk;
    assign pm_mask = (fno >= 1 && fno <= 10) ? msk[fno] : 8'h00;
    assign pm_code = (fno >= 1 && fno <= 10) ? cod[fno] : 4'h9;

    tts_tc_source src (.clk(clk), .rst(rst), .err_mask(pm_mask),
        .err_code(pm_code), .link_ck(in_ck), .link_d(in_d),
        .link_fs(in_fs), .frame_no(fno), .byte_no(bno));

    tts_trail_sink dut (.CLK(clk), .RST(rst), .IN_CK(in_ck), .IN_D(in_d),
        .IN_FS(in_fs), .SERVER_SIGNAL_FAIL(server_signal_fail), .AVS_ADDRESS(av_a),
        .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd),
        .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_q),
        .AVS_WAITREQUEST(av_wait), .OUT_CK(out_ck), .OUT_D(out_d),
        .OUT_FS(out_fs), .ACCEPTED_TRACE_ID(acc_ti),
        .TC_UNEQUIPPED_DEFECT(uneq), .TC_CONNECTION_LOSS_DEFECT(loss),
        .TRACE_MISMATCH_DEFECT(tim), .FAR_DEFECT_INDICATION_DEFECT(rdi),
        .FAR_OUTGOING_DEFECT_DEFECT(odi), .INCOMING_ALARM_DEFECT(iais),
        .ALARM_INSERT_REQUEST(aisr), .NEAR_ERRORED_TC_BLOCK(ntc),
        .NEAR_ERRORED_VC_BLOCK(nvc), .FAR_ERRORED_TC_BLOCK(ftc),
        .FAR_ERRORED_VC_BLOCK(fvc));

    // Pulses are gathered per frame; the output parity checks compensation.
    always @(posedge clk) begin
        ock <= out_ck;
        seen <= (bno == 1) ? 4'h0 : seen | {ntc, nvc, ftc, fvc};
        if (out_ck === 1'b1 && ock === 1'b0) begin
            oi = out_fs ? 0 : oi + 1;
            ppar = out_fs ? cpar : ppar;
            cpar = out_fs ? out_d : cpar ^ out_d;
            if (oi == 85) begin
                ob3 = out_d ^ ppar;
            end
            if (oi == 680) begin
                on1 = out_d;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task conclude;
        $display("compared %0d, mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic av(input logic w, input logic [5:0] a,
                      input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
        @(posedge clk);
        av_a <= a;
        av_wd <= wd;
        av_be <= be;
        av_wr <= w;
        av_rd <= !w;
        @(posedge clk);
        while (av_wait !== 1'b0) begin
            @(posedge clk);
        end
        rd = av_q;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : av

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] r;
        av(1'b0, a, 32'h0, 4'h0, r);
        chk(r, exp);
    endtask : rd_chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        logic [31:0] r;
        av(1'b1, a, d, be, r);
    endtask : wr

    task automatic wait_at(input int f, input int b);
        while (!(fno > f || (fno == f && bno >= b))) begin
            @(posedge clk);
        end
    endtask : wait_at

    function automatic logic [3:0] exp_flags(input int f);
        int n;
        logic [3:0] v;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            n += msk[f][i];
        end
        v = (cod[f] <= 4'h8) ? cod[f] : 4'h0;
        return {n != int'(v), msk[f] != 8'h00, f[0], f[1]};
    endfunction : exp_flags

    task automatic regs;
        rd_chk(REG_CTRL, 32'h0);
        rd_chk(REG_STATUS, 32'h42);
        rd_chk(6'h3C, 32'h0);
        wr(REG_ACC_TI, 32'hFFFFFFFF, 4'hF);
        rd_chk(REG_ACC_TI, 32'h0);
        chk(acc_ti[127:96], 32'h0);
        wr(REG_CTRL, 32'h1, 4'h1);
        rd_chk(REG_CTRL, 32'h1);
        wr(REG_EXP_TI, 32'h12345678, 4'h3);
        rd_chk(REG_EXP_TI, 32'h5678);
        repeat (10) @(posedge clk);
        chk(tim, 1'b0);
        server_signal_fail <= 1'b1;
        repeat (4) @(posedge clk);
        wr(REG_CTRL, 32'h0, 4'h1);
        repeat (10) @(posedge clk);
        chk(tim, 1'b0);
        server_signal_fail <= 1'b0;
        repeat (10) @(posedge clk);
        chk(tim, 1'b1);
        rd_chk(REG_STATUS, 32'h46);
        wr(REG_EXP_TI, 32'h0, 4'hF);
        repeat (10) @(posedge clk);
        chk(tim, 1'b0);
    endtask : regs

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int f = 1; f <= 10; f++) begin
            wait_at(f, 2);
            if (f == 1) begin
                regs();
            end
            wait_at(f, 720);
            if (f >= 2) begin
                chk(seen, exp_flags(f));
            end
            if (f == 5 || f == 9) begin
                chk(iais, 1'b1);
            end
            if (f == 4 || f == 10) begin
                chk(iais, 1'b0);
            end
            if (f <= 7) begin
                chk({loss, aisr, on1}, {2'b11, AIS_BYTE});
            end
            if (f >= 9) begin
                chk({loss, aisr, on1}, {2'b00, N1_TERM});
            end
            if (f == 10) begin
                chk(ob3, msk[10]);
            end
            chk({uneq, tim, rdi, odi}, 4'h0);
        end
        conclude();
    end

    initial begin
        repeat (130000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : tb
`default_nettype wire
